// ---- verilog/qsf_defs.svh ----
// Constants of the quad switch fault logic: register map, reset values, timing.
// Assumes a single 250 MHz clock; included by the deglitch counter and the top module.
`ifndef QSF_DEFS_SVH
`define QSF_DEFS_SVH
`define QSF_NCH 4
`define QSF_CLK_MHZ 250
`define QSF_T_OFF_DEG_US 20
`define QSF_OFF_DEG_CYC (`QSF_T_OFF_DEG_US * `QSF_CLK_MHZ)
`define QSF_REG_CTRL 4'h0
`define QSF_REG_STATUS 4'h4
`define QSF_REG_MODE 4'h8
`define QSF_CTRL_RST 4'hf
`define QSF_STATUS_PAD 12'h000
`define QSF_MODE_PAD 21'h00_0000
`define QSF_CTRL_PAD 28'h000_0000
`define QSF_CNT_ONE 16'h0001
`endif

// ---- verilog/qsf_pkg.sv ----
// Types shared by the quad switch fault logic modules.
// Assumes nothing beyond the constants header.
package qsf_pkg;
    // Working mode of the whole device.
    typedef enum logic [1:0] {QSF_NORMAL, QSF_STANDBY, QSF_STANDBY_DIAG} qsf_mode_t;
    // Per-channel comparator results.
    typedef struct packed {
        logic ilim;
        logic ol_off;
        logic tsd_hot;
        logic tsd_cool;
        logic tsd_rst;
        logic sw_hot;
        logic sw_cool;
    } qsf_cmp_t;
    // Device-wide supply and ground monitors.
    typedef struct packed {
        logic undervoltage_lockout;
        logic gnd_loss;
        logic sup_loss;
    } qsf_sup_t;
    // Per-channel state seen by the top.
    typedef struct packed {
        logic out_on;
        logic fault;
        logic tsd_flag;
        logic sw_flag;
        logic reduced;
    } qsf_chst_t;
endpackage : qsf_pkg

// ---- verilog/qsf_dglt.sv ----
// Deglitch counter: output rises once the input level has held long enough.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/100ps
module qsf_dglt #(
    parameter logic [15:0] CYCLES = 16'd5000
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_level,
    output logic o_done
);
`include "qsf_defs.svh"
    logic [15:0] cnt;
    // Count while the level holds; any drop restarts the wait.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= '0;
            o_done <= 1'b0;
        end
        else if (!i_level)
        begin
            cnt <= '0;
            o_done <= 1'b0;
        end
        else if (cnt < CYCLES)
            cnt <= cnt + `QSF_CNT_ONE;
        else
            o_done <= 1'b1;
    end
endmodule : qsf_dglt

// ---- verilog/qsf_chan.sv ----
// One channel of fault handling: overcurrent, open load, thermal shutdown, swing.
// Assumes comparator flags and controls are already sampled on the clock.
`timescale 1ns/100ps
module qsf_chan import qsf_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_on,
    input wire logic i_latch,
    input wire logic i_force_off,
    input wire qsf_cmp_t i_cmp,
    output qsf_chst_t o_st
);
    logic on_d;
    logic tsd_off;
    logic tsd_flag;
    logic sw_off;
    logic reduced;
    logic fault;
    wire toggle = i_on ^ on_d;
    // Latch mode waits for a toggle, auto-retry waits for cooling; select is live.
    wire tsd_release = i_latch ? toggle : i_cmp.tsd_cool;
    wire next_tsd_off = i_cmp.tsd_hot | (tsd_off & ~tsd_release);
    wire flag_clear = toggle | (~i_latch & i_cmp.tsd_rst);
    wire next_tsd_flag = i_cmp.tsd_hot | (tsd_flag & ~flag_clear);
    wire next_sw_off = i_cmp.sw_hot | (sw_off & ~i_cmp.sw_cool);
    // Reduced limit survives retries and only drops on a toggle after recovery.
    wire next_reduced = i_cmp.tsd_hot | (reduced & ~(toggle & ~tsd_off));
    wire oc_fault = i_on & i_cmp.ilim;
    wire ol_fault = ~i_on & i_cmp.ol_off;
    wire next_fault = oc_fault | ol_fault | tsd_flag | sw_off;
    // Per-channel thermal state, so a hot channel never disturbs the others.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            on_d <= 1'b0;
            tsd_off <= 1'b0;
            tsd_flag <= 1'b0;
            sw_off <= 1'b0;
            reduced <= 1'b0;
            fault <= 1'b0;
        end
        else
        begin
            on_d <= i_on;
            tsd_off <= next_tsd_off;
            tsd_flag <= next_tsd_flag;
            sw_off <= next_sw_off;
            reduced <= next_reduced;
            fault <= next_fault;
        end
    end
    assign o_st.out_on = i_on & ~i_force_off & ~tsd_off & ~sw_off;
    assign o_st.fault = fault;
    assign o_st.tsd_flag = tsd_flag;
    assign o_st.sw_flag = sw_off;
    assign o_st.reduced = reduced;

    property p_tsd_off;
        @(posedge i_clk) disable iff (!i_rst_n) i_cmp.tsd_hot |=> !o_st.out_on;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("output on after shutdown");
    property p_latch_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_latch && tsd_off && !toggle) |=> tsd_off;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch retried");
    property p_latch_flag;
        @(posedge i_clk) disable iff (!i_rst_n)
            (i_latch && o_st.tsd_flag && !toggle) |=> o_st.tsd_flag;
    endproperty
    a_latch_flag: assert property (p_latch_flag) else $error("latch flag lost");
    property p_auto_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
            (!i_latch && i_cmp.tsd_rst && !i_cmp.tsd_hot) |=> !o_st.tsd_flag;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("flag kept");
    property p_oc_flag;
        @(posedge i_clk) disable iff (!i_rst_n) (i_on && i_cmp.ilim) |=> o_st.fault;
    endproperty
    a_oc_flag: assert property (p_oc_flag) else $error("overcurrent not flagged");
    property p_reduced;
        @(posedge i_clk) disable iff (!i_rst_n) i_cmp.tsd_hot |=> o_st.reduced;
    endproperty
    a_reduced: assert property (p_reduced) else $error("limit not reduced");
    sequence s_swing_in;
        i_cmp.sw_hot;
    endsequence
    sequence s_swing_out;
        !i_cmp.sw_hot && i_cmp.sw_cool;
    endsequence
    property p_swing;
        @(posedge i_clk) disable iff (!i_rst_n)
            (s_swing_in |=> o_st.sw_flag && !o_st.out_on) and (s_swing_out |=> !o_st.sw_flag);
    endproperty
    a_swing: assert property (p_swing) else $error("swing handling wrong");
endmodule : qsf_chan

// ---- verilog/qsf_top.sv ----
// Quad switch fault logic: samples pins and comparators, runs four channel
// fault engines, drives gates, open-drain alarms and the sense mux selection.
// Assumes all inputs are synchronous to I_REF_CLK and an Avalon-MM master
// that holds each request until it sees waitrequest low.
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "qsf_defs.svh"
module qsf_top import qsf_pkg::*; #(
    parameter logic [15:0] OFF_DEG_CYCLES = 16'(`QSF_OFF_DEG_CYC)
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic [3:0] I_CHANNEL_ON_INPUT,
    input wire logic I_THERMAL_LATCH_SELECT,
    input wire logic I_DIAGNOSTICS_GATE,
    input wire logic I_MUX_BIT_HIGH,
    input wire logic I_MUX_BIT_LOW,
    input wire qsf_cmp_t [3:0] I_CH_CMP,
    input wire qsf_sup_t I_SUPPLY_CMP,
    input wire logic [3:0] I_CHANNEL_ALARM_N_I,
    input wire logic I_GLOBAL_ALARM_N_I,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic [3:0] O_CH_OUT,
    output logic [3:0] O_REDUCED_LIMIT,
    output logic [3:0] O_CHANNEL_ALARM_N_O,
    output logic [3:0] O_CHANNEL_ALARM_N_OE,
    output logic O_GLOBAL_ALARM_N_O,
    output logic O_GLOBAL_ALARM_N_OE,
    output logic [1:0] O_SENSE_SEL,
    output logic O_SENSE_FAULT,
    output logic O_SENSE_OE,
    output qsf_mode_t O_MODE
);

    // Sampled copies of every non-bus pin and comparator flag.
    logic [3:0] on_s;
    logic latch_s;
    logic diag_s;
    logic [1:0] sel_s;
    qsf_cmp_t [3:0] cmp_s;
    qsf_sup_t sup_s;
    logic [3:0] alarm_in_s;
    logic global_in_s;

    // Software channel enable mask; a cleared bit keeps that channel off.
    logic [3:0] ctrl_mask;

    // Channel state gathered from the four fault engines.
    qsf_chst_t [3:0] ch_st;
    logic [3:0] ch_out;
    logic [3:0] ch_fault;
    logic [3:0] ch_tsd;
    logic [3:0] ch_sw;
    logic [3:0] ch_red;
    // Comparator flags regrouped by kind for the pin checks.
    logic [3:0] cmp_ilim;
    logic [3:0] cmp_open;
    logic [3:0] cmp_hot;

    // Mode machine and standby deglitch.
    qsf_mode_t next_mode;
    logic idle_done;

    // Bus slave state.
    logic [31:0] next_readdata;

    // Comparators are asynchronous to nothing we know of, so they are taken
    // as plain synchronous flags and registered once before any decision.
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            on_s <= '0;
            latch_s <= 1'b0;
            diag_s <= 1'b0;
            sel_s <= '0;
            cmp_s <= '0;
            sup_s <= '0;
            alarm_in_s <= '1;
            global_in_s <= 1'b1;
        end
        else
        begin
            on_s <= I_CHANNEL_ON_INPUT;
            latch_s <= I_THERMAL_LATCH_SELECT;
            diag_s <= I_DIAGNOSTICS_GATE;
            sel_s <= {I_MUX_BIT_HIGH, I_MUX_BIT_LOW};
            cmp_s <= I_CH_CMP;
            sup_s <= I_SUPPLY_CMP;
            alarm_in_s <= I_CHANNEL_ALARM_N_I;
            global_in_s <= I_GLOBAL_ALARM_N_I;
        end
    end

    // Any supply-side hazard blocks all gates, regardless of the on inputs.
    wire sup_block = sup_s.undervoltage_lockout | sup_s.gnd_loss | sup_s.sup_loss;

    // Four independent fault engines; the thermal select is shared and live,
    // so a falling select moves latched channels into auto-retry at once.
    genvar g;
    generate
        for (g = 0; g < `QSF_NCH; g++)
        begin : g_ch
            qsf_chan u_chan (
                .i_clk(I_REF_CLK),
                .i_rst_n(I_RESETN),
                .i_on(on_s[g]),
                .i_latch(latch_s),
                .i_force_off(sup_block | ~ctrl_mask[g]),
                .i_cmp(cmp_s[g]),
                .o_st(ch_st[g])
            );
            assign ch_out[g] = ch_st[g].out_on;
            assign ch_fault[g] = ch_st[g].fault;
            assign ch_tsd[g] = ch_st[g].tsd_flag;
            assign ch_sw[g] = ch_st[g].sw_flag;
            assign ch_red[g] = ch_st[g].reduced;
            assign cmp_ilim[g] = cmp_s[g].ilim;
            assign cmp_open[g] = cmp_s[g].ol_off;
            assign cmp_hot[g] = cmp_s[g].tsd_hot;
        end
    endgenerate

    // Standby needs every on input low for the whole deglitch time, so a
    // short low pulse in PWM operation never drops the part into standby.
    qsf_dglt #(
        .CYCLES(OFF_DEG_CYCLES)
    ) u_dglt (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RESETN),
        .i_level(on_s == 4'h0),
        .o_done(idle_done)
    );

    // Working mode selection.
    always_comb
    begin
        next_mode = O_MODE;
        case (O_MODE)
            QSF_NORMAL:
                if (idle_done && on_s == 4'h0)
                    next_mode = diag_s ? QSF_STANDBY_DIAG : QSF_STANDBY;
            QSF_STANDBY, QSF_STANDBY_DIAG:
                if (on_s != 4'h0)
                    next_mode = QSF_NORMAL;
                else
                    next_mode = diag_s ? QSF_STANDBY_DIAG : QSF_STANDBY;
            default:
                next_mode = QSF_NORMAL;
        endcase
    end

    // Diagnostics run in normal mode and in standby with diagnostics; plain
    // standby keeps sense and alarms released to save supply current.
    wire diag_active = diag_s & (O_MODE != QSF_STANDBY);
    wire [3:0] alarm_drive = ch_fault & {4{diag_active}};
    wire global_drive = (|ch_fault) & diag_active;
    wire sense_fault = ch_fault[sel_s] & diag_active;

    // Output stage: every pin comes straight from a flip-flop. Open-drain
    // pins only ever pull low, so their data flops stay at zero.
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_MODE <= QSF_NORMAL;
            O_CH_OUT <= '0;
            O_REDUCED_LIMIT <= '0;
            O_CHANNEL_ALARM_N_O <= '0;
            O_CHANNEL_ALARM_N_OE <= '0;
            O_GLOBAL_ALARM_N_O <= 1'b0;
            O_GLOBAL_ALARM_N_OE <= 1'b0;
            O_SENSE_SEL <= '0;
            O_SENSE_FAULT <= 1'b0;
            O_SENSE_OE <= 1'b0;
        end
        else
        begin
            O_MODE <= next_mode;
            O_CH_OUT <= ch_out;
            O_REDUCED_LIMIT <= ch_red;
            O_CHANNEL_ALARM_N_O <= '0;
            O_CHANNEL_ALARM_N_OE <= alarm_drive;
            O_GLOBAL_ALARM_N_O <= 1'b0;
            O_GLOBAL_ALARM_N_OE <= global_drive;
            O_SENSE_SEL <= sel_s;
            O_SENSE_FAULT <= sense_fault;
            O_SENSE_OE <= diag_active;
        end
    end

    // Register decode. Unmapped addresses read zero and ignore writes.
    wire req = I_AVS_READ | I_AVS_WRITE;
    wire hit_ctrl = (I_AVS_ADDRESS == `QSF_REG_CTRL);
    wire hit_status = (I_AVS_ADDRESS == `QSF_REG_STATUS);
    wire hit_mode = (I_AVS_ADDRESS == `QSF_REG_MODE);
    wire [31:0] rd_ctrl = {`QSF_CTRL_PAD, ctrl_mask};
    wire [31:0] rd_status = {`QSF_STATUS_PAD, ch_red, ch_sw, ch_tsd, O_CH_OUT, ch_fault};
    wire [31:0] rd_mode = {`QSF_MODE_PAD, global_in_s, alarm_in_s, sup_s, latch_s, O_MODE};
    wire wr_commit = I_AVS_WRITE & ~O_AVS_WAITREQUEST & hit_ctrl;

    always_comb
    begin
        next_readdata = '0;
        if (hit_ctrl)
            next_readdata = rd_ctrl;
        else if (hit_status)
            next_readdata = rd_status;
        else if (hit_mode)
            next_readdata = rd_mode;
    end

    // One wait cycle per access: waitrequest drops the cycle after the
    // request appears and rises again at the accepting edge. Costs a cycle
    // per access but keeps every bus output on a flop.
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= '0;
        end
        else
        begin
            O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
            if (I_AVS_READ & O_AVS_WAITREQUEST)
                O_AVS_READDATA <= next_readdata;
        end
    end

    // Channel enable mask, written only at the accepting edge.
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            ctrl_mask <= `QSF_CTRL_RST;
        else if (wr_commit)
            ctrl_mask <= I_AVS_WRITEDATA[3:0];
    end

    property p_undervoltage_lockout_off;
        @(posedge I_REF_CLK) disable iff (!I_RESETN) sup_s.undervoltage_lockout |=> O_CH_OUT == 4'h0;
    endproperty
    a_undervoltage_lockout_off: assert property (p_undervoltage_lockout_off) else $error("output on in undervoltage");
    property p_gnd_off;
        @(posedge I_REF_CLK) disable iff (!I_RESETN) sup_s.gnd_loss |=> O_CH_OUT == 4'h0;
    endproperty
    a_gnd_off: assert property (p_gnd_off) else $error("output on after ground loss");
    property p_sup_off;
        @(posedge I_REF_CLK) disable iff (!I_RESETN) sup_s.sup_loss |=> O_CH_OUT == 4'h0;
    endproperty
    a_sup_off: assert property (p_sup_off) else $error("output on after supply loss");
    property p_global;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            (diag_active && ch_fault != 4'h0) |=> O_GLOBAL_ALARM_N_OE;
    endproperty
    a_global: assert property (p_global) else $error("global alarm not driven");
    property p_gate;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            !diag_s |=> !O_SENSE_OE && O_CHANNEL_ALARM_N_OE == 4'h0 && !O_GLOBAL_ALARM_N_OE;
    endproperty
    a_gate: assert property (p_gate) else $error("diagnostic pins driven while gated");
    property p_sel;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##1 O_SENSE_SEL == $past(sel_s) && O_SENSE_FAULT == $past(sense_fault);
    endproperty
    a_sel: assert property (p_sel) else $error("sense channel wrong");
    sequence s_stby_enter;
        O_MODE == QSF_NORMAL ##1 O_MODE != QSF_NORMAL;
    endsequence
    property p_stby;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            s_stby_enter |-> $past(on_s, 1) == 4'h0 && $past(on_s, 2) == 4'h0;
    endproperty
    a_stby: assert property (p_stby) else $error("standby without idle inputs");
    property p_mode_diag;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            (O_MODE != QSF_NORMAL && on_s == 4'h0) |=> O_MODE == QSF_STANDBY_DIAG ||
            !$past(diag_s);
    endproperty
    a_mode_diag: assert property (p_mode_diag) else $error("standby mode wrong");
    property p_wait;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            (req && O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer timing wrong");
    // Helper terms kept as plain signals so the checks below can look back
    // at them; a channel with no live cause must drop its fault.
    wire [3:0] open_off = cmp_open & ~on_s;
    wire [3:0] no_cause = ~(cmp_ilim & on_s) & ~open_off & ~ch_tsd & ~ch_sw;
    wire [3:0] open_on = cmp_open & on_s & no_cause;
    property p_oc_clear;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##1 (ch_fault & $past(no_cause)) == 4'h0;
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("fault kept without cause");
    property p_open_off;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##1 (ch_fault & $past(open_off)) == $past(open_off);
    endproperty
    a_open_off: assert property (p_open_off) else $error("open load not flagged");
    property p_open_on;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##2 (O_CHANNEL_ALARM_N_OE & $past(open_on, 2)) == 4'h0;
    endproperty
    a_open_on: assert property (p_open_on) else $error("on-state open drove alarm");
    property p_alarm;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##1 O_CHANNEL_ALARM_N_OE == ($past(ch_fault) & {4{$past(diag_active)}});
    endproperty
    a_alarm: assert property (p_alarm) else $error("channel alarm wrong");
    property p_hot_pin;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##2 (O_CH_OUT & $past(cmp_hot, 2)) == 4'h0;
    endproperty
    a_hot_pin: assert property (p_hot_pin) else $error("hot channel still on");
    property p_red_pin;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##2 (O_REDUCED_LIMIT & $past(cmp_hot, 2)) == $past(cmp_hot, 2);
    endproperty
    a_red_pin: assert property (p_red_pin) else $error("reduced limit pin low");
    property p_mask;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            ##1 (O_CH_OUT & ~$past(ctrl_mask)) == 4'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("masked channel on");
    property p_wake;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            on_s != 4'h0 |=> O_MODE == QSF_NORMAL;
    endproperty
    a_wake: assert property (p_wake) else $error("standby with an input high");
    property p_idle_wait;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            !req |=> O_AVS_WAITREQUEST;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low while idle");
    property p_rdata;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            (I_AVS_READ && O_AVS_WAITREQUEST) |=> O_AVS_READDATA == $past(next_readdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data not loaded");
    property p_sense_on;
        @(posedge I_REF_CLK) disable iff (!I_RESETN)
            diag_active |=> O_SENSE_OE;
    endproperty
    a_sense_on: assert property (p_sense_on) else $error("sense not driven");
endmodule : qsf_top

// ---- test/qsf_mcu_model.sv ----
// Controller model: pull-ups on the open-drain alarm wires and a sense-mux scanner.
// Assumes alarm enables and sense outputs come straight from the design top.
`timescale 1ns/100ps
module qsf_mcu (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_alarm_oe,
    input wire logic i_global_oe,
    input wire logic [1:0] i_sense_sel,
    input wire logic i_sense_fault,
    input wire logic i_sense_oe,
    output logic [3:0] o_alarm_wire,
    output logic o_global_wire,
    output logic o_sel_high,
    output logic o_sel_low,
    output logic [3:0] o_seen
);
    logic [4:0] step;
    // Pull-ups win whenever no party sinks the wire, so a released wire never keeps a stale low.
    assign o_alarm_wire = ~i_alarm_oe;
    assign o_global_wire = ~i_global_oe;
    assign {o_sel_high, o_sel_low} = step[4:3];
    // Each channel is held for eight cycles and sampled late, after the sense path settles.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            step <= 5'h00;
            o_seen <= 4'h0;
        end
        else
        begin
            step <= step + 5'h01;
            if (step[2:0] == 3'h7 && i_sense_oe && i_sense_sel == step[4:3])
            begin
                o_seen[step[4:3]] <= i_sense_fault;
            end
        end
    end
endmodule : qsf_mcu

// ---- test/testbench.sv ----
// Self-checking bench for the quad switch fault logic with a controller model.
// Assumes a 250 MHz clock and a shortened standby deglitch count of 20 cycles.
`timescale 1ns/100ps
module testbench import qsf_pkg::*;;
    localparam qsf_cmp_t IDLE = 7'h0d;
    localparam qsf_cmp_t ILIM = 7'h4d;
    localparam qsf_cmp_t OLOF = 7'h2d;
    localparam qsf_cmp_t HOT = 7'h11;
    localparam qsf_cmp_t WARM = 7'h09;
    localparam qsf_cmp_t SWH = 7'h0e;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] on = 4'h0;
    logic latch = 1'b0;
    logic diag = 1'b1;
    qsf_cmp_t [3:0] cmp = {4{IDLE}};
    qsf_sup_t sup = 3'h0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, d;
    logic wait_r, gl_o, gl_oe, sfault, soe, gl_w, mh, ml;
    logic [3:0] ch_out, red, al_o, al_oe, al_w, seen;
    logic [1:0] sel;
    qsf_mode_t mode;
    int err_count = 0;
    int n_tests = 0;
    // Free-running reference clock.
    always #2 clk = ~clk;
    qsf_top #(.OFF_DEG_CYCLES(16'h0014)) i_dut (.I_REF_CLK(clk), .I_RESETN(rst_n),
        .I_CHANNEL_ON_INPUT(on), .I_THERMAL_LATCH_SELECT(latch), .I_DIAGNOSTICS_GATE(diag),
        .I_MUX_BIT_HIGH(mh), .I_MUX_BIT_LOW(ml), .I_CH_CMP(cmp), .I_SUPPLY_CMP(sup),
        .I_CHANNEL_ALARM_N_I(al_w), .I_GLOBAL_ALARM_N_I(gl_w), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wait_r), .O_CH_OUT(ch_out), .O_REDUCED_LIMIT(red),
        .O_CHANNEL_ALARM_N_O(al_o), .O_CHANNEL_ALARM_N_OE(al_oe), .O_GLOBAL_ALARM_N_O(gl_o),
        .O_GLOBAL_ALARM_N_OE(gl_oe), .O_SENSE_SEL(sel), .O_SENSE_FAULT(sfault),
        .O_SENSE_OE(soe), .O_MODE(mode));
    qsf_mcu i_mcu (.i_clk(clk), .i_rst_n(rst_n), .i_alarm_oe(al_oe), .i_global_oe(gl_oe),
        .i_sense_sel(sel), .i_sense_fault(sfault), .i_sense_oe(soe), .o_alarm_wire(al_w),
        .o_global_wire(gl_w), .o_sel_high(mh), .o_sel_low(ml), .o_seen(seen));
    // Comparison of one observed value against its expectation.
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // One Avalon access held until waitrequest is sampled low, bounded by a timeout.
    task av(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= wd;
        @(posedge clk);
        while (wait_r !== 1'b0 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) err_count++;
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av
    task rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        av(1'b0, a, 32'h0, d);
        chk(d & m, e);
    endtask : rchk
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // Watchdog: the scenarios need well under a thousand cycles.
    initial
    begin
        cyc(5000);
        err_count++;
        report_and_stop();
    end
    // Main sequence of scenarios.
    initial
    begin
        cyc(4);
        rst_n <= 1'b1;
        chk(wait_r, 32'h1);
        rchk(4'h0, 32'hffff_ffff, 32'h0000_000f);
        on <= 4'h1;
        cyc(6);
        cmp[0] <= ILIM;
        cyc(6);
        chk(al_oe, 4'h1);
        chk(gl_w, 32'h0);
        chk({gl_o, al_o}, 5'h00);
        rchk(4'h4, 32'h0000_000f, 32'h0000_0001);
        cmp[0] <= IDLE;
        cyc(6);
        chk({gl_oe, al_oe}, 5'h00);
        cmp[1] <= OLOF;
        cyc(6);
        chk({gl_oe, al_oe}, 5'h12);
        cyc(80);
        chk(seen, 4'h2);
        diag <= 1'b0;
        cyc(6);
        chk({soe, gl_oe, al_oe}, 6'h00);
        diag <= 1'b1;
        on <= 4'h3;
        cyc(6);
        chk({gl_oe, al_oe}, 5'h00);
        cmp[1] <= IDLE;
        on <= 4'h5;
        cyc(6);
        cmp[2] <= HOT;
        cyc(6);
        chk(ch_out, 4'h1);
        chk(red, 4'h4);
        rchk(4'h4, 32'h0000_0f00, 32'h0000_0400);
        cmp[2] <= WARM;
        cyc(6);
        chk({red, ch_out}, 8'h45);
        rchk(4'h4, 32'h0000_0f00, 32'h0000_0400);
        cmp[2] <= IDLE;
        cyc(6);
        rchk(4'h4, 32'h0000_0f00, 32'h0000_0000);
        latch <= 1'b1;
        on <= 4'h8;
        cyc(6);
        cmp[3] <= HOT;
        cyc(6);
        cmp[3] <= IDLE;
        cyc(6);
        chk(ch_out, 4'h0);
        rchk(4'h4, 32'h0000_0f00, 32'h0000_0800);
        on <= 4'h0;
        cyc(2);
        on <= 4'h8;
        cyc(6);
        rchk(4'h4, 32'h0000_0ff0, 32'h0000_0080);
        cmp[3] <= HOT;
        cyc(6);
        cmp[3] <= WARM;
        cyc(6);
        chk(ch_out, 4'h0);
        latch <= 1'b0;
        cyc(6);
        chk(ch_out, 4'h8);
        cmp[3] <= IDLE;
        on <= 4'h1;
        cmp[0] <= SWH;
        cyc(6);
        chk(ch_out, 4'h0);
        rchk(4'h4, 32'h0000_f000, 32'h0000_1000);
        cmp[0] <= IDLE;
        cyc(6);
        chk(ch_out, 4'h1);
        rchk(4'h4, 32'h0000_f000, 32'h0000_0000);
        on <= 4'hf;
        for (int i = 0; i < 3; i++)
        begin
            sup <= 3'(1 << i);
            cyc(6);
            chk(ch_out, 4'h0);
            sup <= 3'h0;
            cyc(6);
            chk(ch_out, 4'hf);
        end
        av(1'b1, 4'h0, 32'h0000_0005, d);
        av(1'b1, 4'h8, 32'hffff_ffff, d);
        cyc(6);
        chk(ch_out, 4'h5);
        rchk(4'h0, 32'hffff_ffff, 32'h0000_0005);
        rchk(4'hc, 32'hffff_ffff, 32'h0);
        rchk(4'h8, 32'hffff_ffff, 32'h0000_07c0);
        on <= 4'h0;
        diag <= 1'b0;
        cyc(10);
        chk(mode, QSF_NORMAL);
        cyc(30);
        chk(mode, QSF_STANDBY);
        on <= 4'h1;
        cyc(4);
        chk(mode, QSF_NORMAL);
        on <= 4'h0;
        diag <= 1'b1;
        cyc(40);
        chk(mode, QSF_STANDBY_DIAG);
        report_and_stop();
    end
endmodule : testbench
